// >>> include/tps_pkg.sv
package tps_pkg;
  // chip operating mode as seen by this block
  typedef enum logic [2:0] {
    TPS_MODE_INIT      = 3'b000,
    TPS_MODE_NORMAL    = 3'b001,
    TPS_MODE_SLEEP_ENT = 3'b010,
    TPS_MODE_FAILSAFE  = 3'b011,
    TPS_MODE_RESTART   = 3'b100
  } tps_mode_e;

  // can failure status field values
  localparam logic [1:0] TPS_CAN_FAIL_NONE = 2'b00;
  localparam logic [1:0] TPS_CAN_FAIL_OT   = 2'b01;

  // aux regulator enable field width and off value
  localparam int         TPS_AUX_EN_W   = 2;
  localparam logic [1:0] TPS_AUX_EN_OFF = 2'b00;

  // consecutive shutdown counting
  localparam int         TPS_SD_CNT_W      = 5;
  localparam logic [4:0] TPS_SD_CNT_LIMIT  = 5'h10;
  localparam logic [4:0] TPS_SD_CNT_ZERO   = 5'h00;
  localparam logic [4:0] TPS_SD_CNT_ONE    = 5'h01;
  localparam int         TPS_EXT_FACTOR    = 64;

  // default cool-down wait, in clock cycles, and restart dwell
  localparam int         TPS_COOLDOWN_CYC  = 1000;
  localparam int         TPS_WAIT_W        = 24;
  localparam int         TPS_RESTART_CYC   = 4;
  localparam logic [2:0] TPS_RESTART_LAST  = 3'(TPS_RESTART_CYC - 1);
endpackage

// >>> src/tps_thermal_supervisor.sv
`timescale 1ns/1ns
module tps_thermal_supervisor
  import tps_pkg::*;
#(
  parameter int COOLDOWN_CYC = tps_pkg::TPS_COOLDOWN_CYC
) (
  // clock, reset, enable
  input  wire logic                            clk,
  input  wire logic                            sys_rst,
  input  wire logic                            clk_en,
  // temperature comparators (already referenced to selected thresholds)
  input  wire logic                            aux_ot_det,
  input  wire logic                            can_ot_det,
  input  wire logic                            main_prewarn_det,
  input  wire logic                            main_shutdown_det,
  // comparator threshold select
  input  wire logic                            thermal_threshold_raise,
  output logic                                 thr_raise_sel,
  // mode requests from the mode controller
  input  wire logic                            sleep_entry_req,
  input  wire logic                            wake_req,
  // host configuration writes
  input  wire logic                            aux_en_wr,
  input  wire logic [tps_pkg::TPS_AUX_EN_W-1:0] aux_en_wdata,
  input  wire logic                            can_normal_en,
  input  wire logic                            shutdown_delay_extend_en,
  // host clear strobes
  input  wire logic                            clr_block_overtemp,
  input  wire logic                            clr_aux_overtemp,
  input  wire logic                            clr_can_fail,
  input  wire logic                            clr_temp_prewarn,
  input  wire logic                            clr_chip_shutdown,
  input  wire logic                            clr_safe_latch,
  // block controls
  output logic [tps_pkg::TPS_AUX_EN_W-1:0]     aux_regulator_enable,
  output logic                                 aux_regulator_on,
  output logic                                 can_tx_enable,
  output logic                                 can_rx_only,
  // status flags
  output logic                                 block_overtemp_flag,
  output logic                                 aux_regulator_overtemp,
  output logic [1:0]                           can_fail_status,
  output logic                                 temp_prewarn_flag,
  output logic                                 chip_shutdown_flag,
  output logic                                 shutdown_safe_latch,
  output logic [tps_pkg::TPS_SD_CNT_W-1:0]     shutdown_count,
  // chip mode
  output tps_pkg::tps_mode_e                   chip_mode
);
  import tps_pkg::*;

  localparam int LONG_CYC = COOLDOWN_CYC * TPS_EXT_FACTOR;
  localparam logic [TPS_WAIT_W-1:0] SHORT_LAST = TPS_WAIT_W'(COOLDOWN_CYC - 1);
  localparam logic [TPS_WAIT_W-1:0] LONG_LAST  = TPS_WAIT_W'(LONG_CYC - 1);

  tps_mode_e                mode_reg;
  logic [TPS_AUX_EN_W-1:0]  aux_en_reg;
  logic                     can_ot_reg;
  logic                     blk_flag_reg;
  logic                     aux_ot_flag_reg;
  logic [1:0]               can_fail_reg;
  logic                     prewarn_reg;
  logic                     sd_flag_reg;
  logic                     safe_reg;
  logic [TPS_SD_CNT_W-1:0]  sd_cnt_reg;
  logic [TPS_WAIT_W-1:0]    wait_reg;
  logic [2:0]               rst_cnt_reg;
  logic                     ext_dly_reg;
  logic                     aux_trip;
  logic                     can_trip;
  logic                     sd_event;
  logic                     wait_done;
  logic [TPS_WAIT_W-1:0]    wait_last;
  logic                     blk_clr_ok;
  logic                     aux_clr_ok;
  logic                     can_clr_ok;
  logic                     pw_clr_ok;
  logic                     sd_clr_ok;

  // block checks only armed while the block is powered, regardless of mode; the shutdown check is masked in fail-safe
  assign aux_trip  = aux_ot_det && (aux_en_reg != TPS_AUX_EN_OFF);
  assign can_trip  = can_ot_det && can_normal_en;
  assign sd_event  = main_shutdown_det && (mode_reg != TPS_MODE_FAILSAFE);
  // long wait only while the safe latch holds and extension is still on
  assign wait_last = ext_dly_reg ? LONG_LAST : SHORT_LAST;
  assign wait_done = (wait_reg >= wait_last);

  // a clear only lands once the condition behind the flag has gone
  assign blk_clr_ok = clr_block_overtemp && !aux_ot_det && !can_ot_det;
  assign aux_clr_ok = clr_aux_overtemp && !aux_ot_det;
  assign can_clr_ok = clr_can_fail && !can_ot_det;
  assign pw_clr_ok  = clr_temp_prewarn && !main_prewarn_det;
  assign sd_clr_ok  = clr_chip_shutdown && !main_shutdown_det &&
                      (mode_reg == TPS_MODE_NORMAL);

  assign thr_raise_sel = thermal_threshold_raise;

  // aux regulator enable: host writes, overtemp clears; no self restart
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aux_en_reg <= TPS_AUX_EN_OFF;
    end else if (clk_en) begin
      if (aux_trip) begin
        aux_en_reg <= TPS_AUX_EN_OFF;
      end else if (aux_en_wr) begin
        aux_en_reg <= aux_en_wdata;
      end
    end
  end

  // can transmitter follows the live condition, so it returns on its own
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      can_ot_reg <= 1'b0;
    end else if (clk_en) begin
      can_ot_reg <= can_trip;
    end
  end

  // sticky flags: a set always wins, a clear needs the condition gone
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      blk_flag_reg <= 1'b0;
    end else if (clk_en) begin
      if (aux_trip || can_trip) begin
        blk_flag_reg <= 1'b1;
      end else if (blk_clr_ok) begin
        blk_flag_reg <= 1'b0;
      end
    end
  end

  // aux regulator overtemp status
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aux_ot_flag_reg <= 1'b0;
    end else if (clk_en) begin
      if (aux_trip) begin
        aux_ot_flag_reg <= 1'b1;
      end else if (aux_clr_ok) begin
        aux_ot_flag_reg <= 1'b0;
      end
    end
  end

  // can failure field
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      can_fail_reg <= TPS_CAN_FAIL_NONE;
    end else if (clk_en) begin
      if (can_trip) begin
        can_fail_reg <= TPS_CAN_FAIL_OT;
      end else if (can_clr_ok) begin
        can_fail_reg <= TPS_CAN_FAIL_NONE;
      end
    end
  end

  // prewarning is report only, nothing else reacts to it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prewarn_reg <= 1'b0;
    end else if (clk_en) begin
      if (main_prewarn_det) begin
        prewarn_reg <= 1'b1;
      end else if (pw_clr_ok) begin
        prewarn_reg <= 1'b0;
      end
    end
  end

  // chip shutdown flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sd_flag_reg <= 1'b0;
    end else if (clk_en) begin
      if (sd_event) begin
        sd_flag_reg <= 1'b1;
      end else if (sd_clr_ok) begin
        sd_flag_reg <= 1'b0;
      end
    end
  end

  // consecutive shutdown counter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sd_cnt_reg <= TPS_SD_CNT_ZERO;
    end else if (clk_en) begin
      if (!shutdown_delay_extend_en) begin
        sd_cnt_reg <= TPS_SD_CNT_ZERO;
      end else if (sd_event) begin
        // saturates so a long run of events cannot wrap back below the limit
        if (sd_cnt_reg != TPS_SD_CNT_LIMIT) begin
          sd_cnt_reg <= sd_cnt_reg + TPS_SD_CNT_ONE;
        end
      end else if (sd_clr_ok) begin
        sd_cnt_reg <= TPS_SD_CNT_ZERO;
      end
    end
  end

  // safe latch: set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      safe_reg <= 1'b0;
    end else if (clk_en) begin
      if (shutdown_delay_extend_en && sd_cnt_reg == TPS_SD_CNT_LIMIT) begin
        safe_reg <= 1'b1;
      end else if (clr_safe_latch) begin
        safe_reg <= 1'b0;
      end
    end
  end

  // extended wait selected while the safe latch holds and extension is on
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_dly_reg <= 1'b0;
    end else if (clk_en) begin
      ext_dly_reg <= shutdown_delay_extend_en && safe_reg;
    end
  end

  // mode sequence: fail-safe, cool-down, restart, normal
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_reg    <= TPS_MODE_INIT;
      wait_reg    <= '0;
      rst_cnt_reg <= '0;
    end else if (clk_en) begin
      case (mode_reg)
        TPS_MODE_INIT: begin
          mode_reg <= sd_event ? TPS_MODE_FAILSAFE : TPS_MODE_NORMAL;
        end
        TPS_MODE_NORMAL: begin
          if (sd_event) begin
            mode_reg <= TPS_MODE_FAILSAFE;
          end else if (sleep_entry_req) begin
            mode_reg <= TPS_MODE_SLEEP_ENT;
          end
        end
        TPS_MODE_SLEEP_ENT: begin
          if (sd_event) begin
            mode_reg <= TPS_MODE_FAILSAFE;
          end else if (wake_req) begin
            // the dwell counter still holds the end count of the last restart
            rst_cnt_reg <= '0;
            mode_reg    <= TPS_MODE_RESTART;
          end
        end
        TPS_MODE_FAILSAFE: begin
          // cool-down only counts while the die is below the threshold
          if (main_shutdown_det) begin
            wait_reg <= '0;
          end else if (wait_done) begin
            wait_reg    <= '0;
            rst_cnt_reg <= '0;
            mode_reg    <= TPS_MODE_RESTART;
          end else begin
            wait_reg <= wait_reg + 1'b1;
          end
        end
        TPS_MODE_RESTART: begin
          if (sd_event) begin
            mode_reg <= TPS_MODE_FAILSAFE;
          end else if (rst_cnt_reg == TPS_RESTART_LAST) begin
            mode_reg <= TPS_MODE_NORMAL;
          end else begin
            rst_cnt_reg <= rst_cnt_reg + 1'b1;
          end
        end
        default: begin
          mode_reg <= TPS_MODE_INIT;
        end
      endcase
    end
  end

  // outputs
  assign aux_regulator_enable   = aux_en_reg;
  assign aux_regulator_on       = (aux_en_reg != TPS_AUX_EN_OFF);
  assign can_tx_enable          = can_normal_en && !can_ot_reg;
  assign can_rx_only            = can_normal_en && can_ot_reg;
  assign block_overtemp_flag    = blk_flag_reg;
  assign aux_regulator_overtemp = aux_ot_flag_reg;
  assign can_fail_status        = can_fail_reg;
  assign temp_prewarn_flag      = prewarn_reg;
  assign chip_shutdown_flag     = sd_flag_reg;
  assign shutdown_safe_latch    = safe_reg;
  assign shutdown_count         = sd_cnt_reg;
  assign chip_mode              = mode_reg;
endmodule // tps_thermal_supervisor

// >>> tb/tps_checker.sv
`timescale 1ns/1ns
module tps_checker
  import tps_pkg::*;
#(
  parameter int COOLDOWN_CYC = TPS_COOLDOWN_CYC
) (
  // clock and reset
  input wire logic                    clk,
  input wire logic                    sys_rst,
  input wire logic                    clk_en,
  // comparators and settings
  input wire logic                    aux_ot_det,
  input wire logic                    can_ot_det,
  input wire logic                    main_shutdown_det,
  input wire logic                    can_normal_en,
  input wire logic                    shutdown_delay_extend_en,
  // watched outputs
  input wire logic [TPS_AUX_EN_W-1:0] aux_regulator_enable,
  input wire logic                    can_tx_enable,
  input wire logic [1:0]              can_fail_status,
  input wire logic                    block_overtemp_flag,
  input wire logic                    chip_shutdown_flag,
  input wire logic                    shutdown_safe_latch,
  input wire logic [TPS_SD_CNT_W-1:0] shutdown_count,
  input wire tps_mode_e               chip_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst || !clk_en);
  logic [15:0] fs_cnt;
  // quiet fail-safe cycles, judged when restart is entered
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fs_cnt <= 16'h0000;
    end else if (clk_en) begin
      if (chip_mode == TPS_MODE_FAILSAFE && !main_shutdown_det) begin
        fs_cnt <= fs_cnt + 16'h0001;
      end else begin
        fs_cnt <= 16'h0000;
      end
    end
  end
  sequence s_restart;
    (chip_mode == TPS_MODE_RESTART) [*4] ##1 chip_mode == TPS_MODE_NORMAL;
  endsequence
  a_aux_trip: assert property (aux_ot_det && aux_regulator_enable != TPS_AUX_EN_OFF |=>
    aux_regulator_enable == TPS_AUX_EN_OFF && block_overtemp_flag) else $error("aux trip missing");
  a_block_gate: assert property (aux_regulator_enable == TPS_AUX_EN_OFF && !can_normal_en
    && !block_overtemp_flag |=> !block_overtemp_flag) else $error("flag set on an off block");
  a_can_trip: assert property (can_ot_det && can_normal_en |=> !can_tx_enable
    && can_fail_status == TPS_CAN_FAIL_OT) else $error("can trip missing");
  a_fs_entry: assert property (main_shutdown_det && chip_mode inside {TPS_MODE_NORMAL,
    TPS_MODE_SLEEP_ENT} |=> chip_mode == TPS_MODE_FAILSAFE && chip_shutdown_flag) else $error("no fail-safe");
  a_cool_wait: assert property ($rose(chip_mode == TPS_MODE_RESTART) &&
    $past(chip_mode) == TPS_MODE_FAILSAFE |-> fs_cnt >=
    ((shutdown_safe_latch && shutdown_delay_extend_en) ? 16'(TPS_EXT_FACTOR * COOLDOWN_CYC)
    : 16'(COOLDOWN_CYC))) else $error("cool-down too short");
  a_restart_seq: assert property ($rose(chip_mode == TPS_MODE_RESTART) |-> s_restart)
    else $error("restart dwell wrong");
  a_count_step: assert property (shutdown_delay_extend_en && main_shutdown_det && chip_mode !=
    TPS_MODE_FAILSAFE && shutdown_count != TPS_SD_CNT_LIMIT |=> shutdown_count ==
    $past(shutdown_count) + TPS_SD_CNT_ONE) else $error("count did not step");
  a_safe_set: assert property (shutdown_count == TPS_SD_CNT_LIMIT && shutdown_delay_extend_en
    |=> shutdown_safe_latch) else $error("safe latch not set");
  a_count_clr: assert property (!shutdown_delay_extend_en |=> shutdown_count == TPS_SD_CNT_ZERO)
    else $error("count not cleared");
endmodule // tps_checker
bind tps_thermal_supervisor tps_checker #(.COOLDOWN_CYC(COOLDOWN_CYC)) u_chk (
  .clk, .sys_rst, .clk_en, .aux_ot_det, .can_ot_det, .main_shutdown_det, .can_normal_en,
  .shutdown_delay_extend_en, .aux_regulator_enable, .can_tx_enable, .can_fail_status,
  .block_overtemp_flag, .chip_shutdown_flag, .shutdown_safe_latch, .shutdown_count, .chip_mode);

// >>> tb/tps_host_model.sv
`timescale 1ns/1ns
module tps_host_model (
  // clock
  input wire logic        clk,
  // clear strobes and enable write
  output logic            clr_block_overtemp,
  output logic            clr_aux_overtemp,
  output logic            clr_can_fail,
  output logic            clr_temp_prewarn,
  output logic            clr_chip_shutdown,
  output logic            clr_safe_latch,
  output logic            aux_en_wr,
  output logic [1:0]      aux_en_wdata
);
  logic [5:0] clr;
  assign clr_block_overtemp = clr[0];
  assign clr_aux_overtemp   = clr[1];
  assign clr_can_fail       = clr[2];
  assign clr_temp_prewarn   = clr[3];
  assign clr_chip_shutdown  = clr[4];
  assign clr_safe_latch     = clr[5];
  initial begin
    clr = 6'h00;
    aux_en_wr = 1'b0;
    aux_en_wdata = 2'h0;
  end
  task automatic pulse(input int b);
    clr[b] = 1'b1;
    @(negedge clk);
    clr[b] = 1'b0;
  endtask
  // data is scrambled once the strobe is gone so a late sample shows up
  task automatic set_aux(input logic [1:0] v);
    aux_en_wdata = v;
    aux_en_wr = 1'b1;
    @(negedge clk);
    aux_en_wr = 1'b0;
    aux_en_wdata = ~v;
  endtask
endmodule // tps_host_model

// >>> tb/tb_thermal_protection_supervisor.sv
`timescale 1ns/1ns
module tb_thermal_protection_supervisor;
  import tps_pkg::*;
  localparam int COOL = 10;
  logic       clk, sys_rst, clk_en, aux_ot_det, can_ot_det, main_prewarn_det, main_shutdown_det;
  logic       thermal_threshold_raise, sleep_entry_req, wake_req, can_normal_en, aux_en_wr;
  logic       shutdown_delay_extend_en, thr_raise_sel, aux_regulator_on, can_tx_enable;
  logic       can_rx_only, block_overtemp_flag, aux_regulator_overtemp, temp_prewarn_flag;
  logic       chip_shutdown_flag, shutdown_safe_latch;
  logic [1:0] aux_en_wdata, aux_regulator_enable, can_fail_status;
  logic [4:0] shutdown_count;
  logic       clr_block_overtemp, clr_aux_overtemp, clr_can_fail, clr_temp_prewarn;
  logic       clr_chip_shutdown, clr_safe_latch;
  tps_mode_e  chip_mode;
  int         n_errors = 0;
  int         total_checks = 0;
  int         cyc = 0;
  int         n;
  tps_thermal_supervisor #(.COOLDOWN_CYC(COOL)) DUT (
    .clk, .sys_rst, .clk_en, .aux_ot_det, .can_ot_det, .main_prewarn_det, .main_shutdown_det,
    .thermal_threshold_raise, .thr_raise_sel, .sleep_entry_req, .wake_req, .aux_en_wr,
    .aux_en_wdata, .can_normal_en, .shutdown_delay_extend_en, .clr_block_overtemp,
    .clr_aux_overtemp, .clr_can_fail, .clr_temp_prewarn, .clr_chip_shutdown, .clr_safe_latch,
    .aux_regulator_enable,
    .aux_regulator_on, .can_tx_enable, .can_rx_only, .block_overtemp_flag, .aux_regulator_overtemp,
    .can_fail_status, .temp_prewarn_flag, .chip_shutdown_flag, .shutdown_safe_latch,
    .shutdown_count, .chip_mode);
  tps_host_model host (.clk, .clr_block_overtemp, .clr_aux_overtemp, .clr_can_fail,
    .clr_temp_prewarn, .clr_chip_shutdown, .clr_safe_latch, .aux_en_wr, .aux_en_wdata);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic to_mode(input tps_mode_e m, output int k);
    k = 0;
    while (chip_mode !== m && k < 1000) begin
      @(negedge clk);
      k++;
    end
  endtask
  task automatic event_run(output int k);
    main_shutdown_det = 1'b1;
    @(negedge clk);
    main_shutdown_det = 1'b0;
    to_mode(TPS_MODE_NORMAL, k);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // the whole run needs about 1600 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    {aux_ot_det, can_ot_det, main_prewarn_det, main_shutdown_det, thermal_threshold_raise} = 5'h00;
    {sleep_entry_req, wake_req, can_normal_en, shutdown_delay_extend_en} = 4'h0;
    clk_en = 1'b1;
    sys_rst = 1'b1;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    chk(chip_mode, TPS_MODE_NORMAL);
    thermal_threshold_raise = 1'b1;
    #1 chk(thr_raise_sel, 16'h0001);
    {aux_ot_det, can_ot_det} = 2'h3;
    repeat (2) @(negedge clk);
    chk({block_overtemp_flag, can_fail_status}, 16'h0000);
    can_ot_det = 1'b0;
    host.set_aux(2'h3);
    @(negedge clk);
    chk({aux_regulator_enable, aux_regulator_overtemp, block_overtemp_flag}, 16'h0003);
    host.pulse(1);
    host.pulse(0);
    chk({aux_regulator_overtemp, block_overtemp_flag}, 16'h0003);
    aux_ot_det = 1'b0;
    host.pulse(1);
    host.pulse(0);
    chk({aux_regulator_enable, aux_regulator_overtemp, block_overtemp_flag}, 16'h0000);
    host.set_aux(2'h1);
    chk({aux_regulator_on, aux_regulator_enable}, 16'h0005);
    {can_normal_en, can_ot_det} = 2'h3;
    @(negedge clk);
    chk({can_tx_enable, can_rx_only, block_overtemp_flag, can_fail_status}, 16'h000d);
    can_ot_det = 1'b0;
    @(negedge clk);
    chk({can_tx_enable, can_fail_status}, 16'h0005);
    host.pulse(2);
    host.pulse(0);
    chk({block_overtemp_flag, can_fail_status}, 16'h0000);
    main_prewarn_det = 1'b1;
    @(negedge clk);
    host.pulse(3);
    chk({temp_prewarn_flag, chip_mode}, {12'h000, 1'b1, TPS_MODE_NORMAL});
    main_prewarn_det = 1'b0;
    host.pulse(3);
    chk(temp_prewarn_flag, 16'h0000);
    {shutdown_delay_extend_en, main_shutdown_det} = 2'h3;
    @(negedge clk);
    chk({chip_shutdown_flag, chip_mode, shutdown_count}, {1'b1, TPS_MODE_FAILSAFE, 5'h01});
    main_shutdown_det = 1'b0;
    host.pulse(4);
    // clock enable low must freeze the cool-down count and every flag
    clk_en = 1'b0;
    repeat (2 * COOL) @(negedge clk);
    chk({chip_shutdown_flag, chip_mode, shutdown_count}, {1'b1, TPS_MODE_FAILSAFE, 5'h01});
    clk_en = 1'b1;
    repeat (COOL - 2) @(negedge clk);
    chk({chip_shutdown_flag, chip_mode}, {1'b1, TPS_MODE_FAILSAFE});
    to_mode(TPS_MODE_RESTART, n);
    to_mode(TPS_MODE_NORMAL, n);
    chk(16'(n), 16'h0004);
    for (int i = 2; i <= 16; i++) begin
      event_run(n);
      chk(shutdown_count, 16'(i));
    end
    chk(shutdown_safe_latch, 16'h0001);
    event_run(n);
    chk(16'(n >= 64 * COOL), 16'h0001);
    host.pulse(4);
    chk({chip_shutdown_flag, shutdown_count}, 16'h0000);
    host.pulse(5);
    chk(shutdown_safe_latch, 16'h0000);
    event_run(n);
    shutdown_delay_extend_en = 1'b0;
    @(negedge clk);
    chk(shutdown_count, 16'h0000);
    sleep_entry_req = 1'b1;
    @(negedge clk);
    {sleep_entry_req, main_shutdown_det} = 2'h1;
    @(negedge clk);
    chk(chip_mode, TPS_MODE_FAILSAFE);
    main_shutdown_det = 1'b0;
    to_mode(TPS_MODE_NORMAL, n);
    chk(chip_mode, TPS_MODE_NORMAL);
    sleep_entry_req = 1'b1;
    @(negedge clk);
    sleep_entry_req = 1'b0;
    chk(chip_mode, TPS_MODE_SLEEP_ENT);
    wake_req = 1'b1;
    @(negedge clk);
    wake_req = 1'b0;
    to_mode(TPS_MODE_NORMAL, n);
    chk(16'(n), 16'h0004);
    results();
  end
endmodule // tb_thermal_protection_supervisor
